// file: include/lmds_pkg.sv
// shared constants and types of the long multiply, divide and saturate unit
package lmds_pkg;
   localparam int DW = 32;
   localparam int AW = 8;
   // register byte offsets
   localparam logic [AW-1:0] ADDR_CTRL   = 8'h00;
   localparam logic [AW-1:0] ADDR_OPA    = 8'h04;
   localparam logic [AW-1:0] ADDR_OPB    = 8'h08;
   localparam logic [AW-1:0] ADDR_RLO    = 8'h0c;
   localparam logic [AW-1:0] ADDR_RHI    = 8'h10;
   localparam logic [AW-1:0] ADDR_SATCFG = 8'h14;
   localparam logic [AW-1:0] ADDR_STATUS = 8'h18;
   // field positions
   localparam int CTRL_OP_LSB    = 0;
   localparam int CTRL_OP_W      = 4;
   localparam int CTRL_DEST_BIT  = 4;
   localparam int SATCFG_N_LSB   = 0;
   localparam int SATCFG_N_W     = 6;
   localparam int SATCFG_ASR_BIT = 6;
   localparam int SATCFG_AMT_LSB = 7;
   localparam int SATCFG_AMT_W   = 5;
   localparam int STAT_BUSY_BIT  = 0;
   localparam int STAT_Q_BIT     = 1;
   localparam int STAT_FLAG_LSB  = 4;
   localparam int STAT_FLAG_W    = 4;
   // reset values
   localparam logic [DW-1:0] RST_WORD  = 32'h0000_0000;
   localparam logic [3:0]    RST_FLAGS = 4'h0;
   // index of the last divide step
   localparam logic [4:0]    DIV_LAST  = 5'h1f;

   typedef enum logic [3:0] {
      OP_UNSIGNED_LONG_MULTIPLY,
      OP_UNSIGNED_LONG_MULTIPLY_ACCUMULATE,
      OP_SIGNED_LONG_MULTIPLY,
      OP_SIGNED_LONG_MULTIPLY_ACCUMULATE,
      OP_SIGNED_DIVIDE,
      OP_UNSIGNED_DIVIDE,
      OP_SIGNED_WORD_SATURATE,
      OP_UNSIGNED_WORD_SATURATE,
      OP_SIGNED_DUAL_HALF_SATURATE,
      OP_UNSIGNED_DUAL_HALF_SATURATE
   } lmds_op_t;

   typedef struct packed {
      logic [SATCFG_AMT_W-1:0] amt;
      logic                    arithmetic_right_shift;
      logic [SATCFG_N_W-1:0]   n;
   } lmds_satcfg_t;
endpackage

// file: rtl/lmds_saturator.sv
// combinational word and dual-halfword saturation with optional pre-shift of the word source
module lmds_saturator import lmds_pkg::*; (
   input  wire lmds_op_t     op,        // saturate flavour
   input  wire lmds_satcfg_t cfg,       // width and shift
   input  wire logic [31:0]  src,       // value to saturate
   output logic      [31:0]  result,    // clamped value
   output logic              saturated, // clamping happened
   output logic      [31:0]  shifted    // word source after shift
);
   // returns {clamped flag, clamped value}
   function automatic logic [32:0] clamp(input logic signed [31:0] v, input logic [5:0] n,
                                         input logic uns);
      logic signed [32:0] hi;
      logic signed [32:0] lo;
      logic signed [32:0] r;
      if (uns) begin
         hi = (33'sd1 <<< n) - 33'sd1;
         lo = 33'sd0;
      end else begin
         hi = (33'sd1 <<< (n - 6'd1)) - 33'sd1;
         lo = -(33'sd1 <<< (n - 6'd1));
      end
      if (v < lo) r = lo;
      else if (v > hi) r = hi;
      else r = 33'(v);
      clamp = {r != 33'(v), r[31:0]};
   endfunction

   logic        uns;
   logic        dual;
   logic [32:0] w;
   logic [32:0] lo_h;
   logic [32:0] hi_h;

   always_comb begin
      uns  = (op == OP_UNSIGNED_WORD_SATURATE) || (op == OP_UNSIGNED_DUAL_HALF_SATURATE);
      dual = (op == OP_SIGNED_DUAL_HALF_SATURATE) || (op == OP_UNSIGNED_DUAL_HALF_SATURATE);
      shifted = cfg.arithmetic_right_shift ? 32'($signed(src) >>> cfg.amt) : (src << cfg.amt);
      w    = clamp(shifted, cfg.n, uns);
      lo_h = clamp({{16{src[15]}}, src[15:0]}, cfg.n, uns);
      hi_h = clamp({{16{src[31]}}, src[31:16]}, cfg.n, uns);
      if (dual) begin
         result    = {hi_h[15:0], lo_h[15:0]};
         saturated = hi_h[32] | lo_h[32];
      end else begin
         result    = w[31:0];
         saturated = w[32];
      end
   end
endmodule

// file: rtl/lmds_divider.sv
// iterative 32-step restoring divider, truncating toward zero
module lmds_divider import lmds_pkg::*; (
   input  wire logic        pclk,      // clock
   input  wire logic        presetn,   // async reset, low
   input  wire logic        start,     // begin a divide
   input  wire logic        is_signed, // two's complement operands
   input  wire logic [31:0] dividend,  // value divided
   input  wire logic [31:0] divisor,   // value dividing
   output logic             busy,      // divide in progress
   output logic             done,      // quotient valid pulse
   output logic      [31:0] quotient   // result
);
   typedef enum logic {DV_IDLE, DV_RUN} lmds_dv_phase_t;
   typedef struct packed {
      lmds_dv_phase_t phase;
      logic [4:0]     cnt;
      logic [32:0]    rem;
      logic [31:0]    quo;
      logic [31:0]    dvs;
      logic [31:0]    a;
      logic [31:0]    b;
      logic           sgn;
      logic           neg;
      logic           done;
   } lmds_dv_state_t;

   function automatic logic [31:0] magnitude(input logic [31:0] v, input logic s);
      magnitude = (s && v[31]) ? (~v + 32'h1) : v;
   endfunction

   lmds_dv_state_t st;
   lmds_dv_state_t next_st;
   logic [32:0]    trial;
   logic [31:0]    qn;

   always_comb begin
      next_st = st;
      next_st.done = 1'b0;
      trial = {st.rem[31:0], st.quo[31]};
      qn = {st.quo[30:0], trial >= {1'b0, st.dvs}};
      case (st.phase)
         DV_IDLE: begin
            if (start) begin
               next_st.a     = dividend;
               next_st.b     = divisor;
               next_st.sgn   = is_signed;
               next_st.neg   = is_signed & (dividend[31] ^ divisor[31]);
               next_st.quo   = magnitude(dividend, is_signed);
               next_st.dvs   = magnitude(divisor, is_signed);
               next_st.rem   = 33'h0;
               next_st.cnt   = 5'h0;
               next_st.phase = DV_RUN;
            end
         end
         DV_RUN: begin
            next_st.rem = (trial >= {1'b0, st.dvs}) ? trial - {1'b0, st.dvs} : trial;
            next_st.quo = qn;
            next_st.cnt = st.cnt + 5'h1;
            if (st.cnt == DIV_LAST) begin
               next_st.phase = DV_IDLE;
               next_st.done  = 1'b1;
               if (st.dvs == 32'h0) next_st.quo = 32'h0;
               else if (st.neg) next_st.quo = ~qn + 32'h1;
            end
         end
         default: next_st.phase = DV_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) st <= '0;
      else st <= next_st;
   end

   assign busy     = (st.phase == DV_RUN);
   assign done     = st.done;
   assign quotient = st.quo;

   default clocking dv_cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_UNSIGNED_DIVIDE: assert property (done && !st.sgn && st.b != 32'h0 |-> quotient == st.a / st.b)
      else $error("unsigned quotient wrong");
   AST_SIGNED_DIVIDE: assert property (done && st.sgn && st.b != 32'h0 && !(st.a == 32'h8000_0000 && st.b == 32'hffff_ffff)
                              |-> $signed(quotient) == $signed(st.a) / $signed(st.b))
      else $error("signed quotient wrong");
   AST_DIV0: assert property (done && st.b == 32'h0 |-> quotient == 32'h0)
      else $error("divide by zero not zero");
   AST_DIVLEN: assert property ($rose(busy) |-> busy [*8] ##25 done)
      else $error("divide length wrong");
endmodule

// file: rtl/lmds_unit.sv
// long multiply, divide and saturate unit with an APB register port
// Functional notes
// - plain long multiply splits product low/high
// - signed multiply uses two's complement operands
// - unsigned accumulate adds product to pair
// - signed accumulate adds signed product to pair
// - condition flags untouched by every operation
// - signed divide of dividend by divisor
// - unsigned divide of dividend by divisor
// - quotients truncate toward zero
// - no destination means dividend register receives quotient
// - signed saturation clamps to n-bit range
// - unsigned saturation clamps negatives to zero
// - clamping sets sticky flag, else unchanged
// - sticky flag cleared only by software write
// - optional shift applied before word saturation
// - unsigned word source read as signed
// - signed halves clamped independently
// - unsigned halves clamped independently
//
// The APB slave port and the placing of the registers are this design's own decisions.
module lmds_unit import lmds_pkg::*; (
   input  wire logic          pclk,     // clock, 200 MHz
   input  wire logic          presetn,  // async reset, low
   input  wire logic [AW-1:0] paddr,    // byte address
   input  wire logic          psel,     // select
   input  wire logic          penable,  // access phase
   input  wire logic          pwrite,   // write direction
   input  wire logic [DW-1:0] pwdata,   // write data
   output logic      [DW-1:0] prdata,   // read data
   output logic               pready,   // transfer done
   output logic               pslverr,  // unmapped address
   output logic               sat_flag  // sticky saturation flag
);
   typedef struct packed {
      logic [31:0]  opa;
      logic [31:0]  opb;
      logic [31:0]  rlo;
      logic [31:0]  rhi;
      lmds_satcfg_t cfg;
      lmds_op_t     op;
      logic         dest;
      logic         exec;
      logic         q;
      logic [3:0]   flags;
      logic [31:0]  prdata;
      logic         pready;
      logic         pslverr;
   } lmds_state_t;

   lmds_state_t        st;
   lmds_state_t        next_st;
   logic               wr;
   logic               busy;
   logic               div_busy;
   logic               div_done;
   logic [31:0]        div_q;
   logic               div_start;
   logic [31:0]        sat_res;
   logic               sat_hit;
   logic [31:0]        sat_shifted;
   logic [63:0]        uprod;
   logic signed [63:0] sprod;
   logic [63:0]        acc;
   logic               is_sat;

   ////////////////////////////////////////////////////////////////////////
   // datapath pieces

   always_comb begin
      uprod = {32'h0, st.opa} * {32'h0, st.opb};
      sprod = $signed(st.opa) * $signed(st.opb);
      acc   = {st.rhi, st.rlo};
      is_sat = (st.op == OP_SIGNED_WORD_SATURATE) || (st.op == OP_UNSIGNED_WORD_SATURATE)
            || (st.op == OP_SIGNED_DUAL_HALF_SATURATE) || (st.op == OP_UNSIGNED_DUAL_HALF_SATURATE);
      div_start = st.exec && ((st.op == OP_SIGNED_DIVIDE) || (st.op == OP_UNSIGNED_DIVIDE));
      // busy spans the quotient write-back cycle too
      busy = st.exec | div_busy | div_done;
      wr = psel & penable & st.pready & pwrite;
   end

   lmds_divider u_div (
      .pclk      (pclk),
      .presetn   (presetn),
      .start     (div_start),
      .is_signed (st.op == OP_SIGNED_DIVIDE),
      .dividend  (st.opa),
      .divisor   (st.opb),
      .busy      (div_busy),
      .done      (div_done),
      .quotient  (div_q)
   );

   lmds_saturator u_sat (
      .op        (st.op),
      .cfg       (st.cfg),
      .src       (st.opa),
      .result    (sat_res),
      .saturated (sat_hit),
      .shifted   (sat_shifted)
   );

   ////////////////////////////////////////////////////////////////////////
   // bus slave and operation sequencing

   always_comb begin
      next_st = st;
      next_st.pready  = 1'b0;
      next_st.pslverr = 1'b0;
      next_st.prdata  = RST_WORD;
      next_st.exec    = 1'b0;
      // setup cycle: latch the answer for the access phase
      if (psel && !penable) begin
         next_st.pready = 1'b1;
         case (paddr)
            ADDR_CTRL:   next_st.prdata = {27'h0, st.dest, st.op};
            ADDR_OPA:    next_st.prdata = st.opa;
            ADDR_OPB:    next_st.prdata = st.opb;
            ADDR_RLO:    next_st.prdata = st.rlo;
            ADDR_RHI:    next_st.prdata = st.rhi;
            ADDR_SATCFG: next_st.prdata = {20'h0, st.cfg};
            ADDR_STATUS: next_st.prdata = {24'h0, st.flags, 2'h0, st.q, busy};
            default:     next_st.pslverr = 1'b1;
         endcase
      end
      if (wr) begin
         case (paddr)
            ADDR_CTRL: begin
               // a start while busy is dropped
               if (!busy) begin
                  next_st.op   = lmds_op_t'(pwdata[CTRL_OP_LSB +: CTRL_OP_W]);
                  next_st.dest = pwdata[CTRL_DEST_BIT];
                  next_st.exec = 1'b1;
               end
            end
            ADDR_OPA:    next_st.opa = pwdata;
            ADDR_OPB:    next_st.opb = pwdata;
            ADDR_RLO:    next_st.rlo = pwdata;
            ADDR_RHI:    next_st.rhi = pwdata;
            ADDR_SATCFG: begin
               next_st.cfg.n   = pwdata[SATCFG_N_LSB +: SATCFG_N_W];
               next_st.cfg.arithmetic_right_shift = pwdata[SATCFG_ASR_BIT];
               next_st.cfg.amt = pwdata[SATCFG_AMT_LSB +: SATCFG_AMT_W];
            end
            ADDR_STATUS: begin
               next_st.q     = pwdata[STAT_Q_BIT];
               next_st.flags = pwdata[STAT_FLAG_LSB +: STAT_FLAG_W];
            end
            default: ;
         endcase
      end
      // results are written after the bus, so hardware wins a same-cycle write
      if (st.exec) begin
         case (st.op)
            OP_UNSIGNED_LONG_MULTIPLY:
               {next_st.rhi, next_st.rlo} = uprod;
            OP_UNSIGNED_LONG_MULTIPLY_ACCUMULATE:
               {next_st.rhi, next_st.rlo} = acc + uprod;
            OP_SIGNED_LONG_MULTIPLY:
               {next_st.rhi, next_st.rlo} = sprod;
            OP_SIGNED_LONG_MULTIPLY_ACCUMULATE:
               {next_st.rhi, next_st.rlo} = acc + sprod;
            OP_SIGNED_WORD_SATURATE, OP_UNSIGNED_WORD_SATURATE,
            OP_SIGNED_DUAL_HALF_SATURATE, OP_UNSIGNED_DUAL_HALF_SATURATE: begin
               next_st.rlo = sat_res;
               if (sat_hit) next_st.q = 1'b1;
            end
            default: ;
         endcase
      end
      if (div_done) begin
         if (st.dest) next_st.rlo = div_q;
         else next_st.opa = div_q;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st       <= '0;
         st.op    <= OP_UNSIGNED_LONG_MULTIPLY;
         st.flags <= RST_FLAGS;
      end else begin
         st <= next_st;
      end
   end

   assign prdata   = st.prdata;
   assign pready   = st.pready;
   assign pslverr  = st.pslverr;
   assign sat_flag = st.q;

   ////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_UMUL: assert property (st.exec && st.op == OP_UNSIGNED_LONG_MULTIPLY
                              |=> {st.rhi, st.rlo} == $past(uprod))
      else $error("unsigned product wrong");
   AST_SMUL: assert property (st.exec && st.op == OP_SIGNED_LONG_MULTIPLY
                              |=> $signed({st.rhi, st.rlo}) == $past(sprod))
      else $error("signed product wrong");
   AST_UMAC: assert property (st.exec && st.op == OP_UNSIGNED_LONG_MULTIPLY_ACCUMULATE
                              |=> {st.rhi, st.rlo} == $past(acc) + $past(uprod))
      else $error("unsigned accumulate wrong");
   AST_SMAC: assert property (st.exec && st.op == OP_SIGNED_LONG_MULTIPLY_ACCUMULATE
                              |=> {st.rhi, st.rlo} == $past(acc) + $past(64'(sprod)))
      else $error("signed accumulate wrong");
   AST_FLAGS: assert property (busy && !(wr && paddr == ADDR_STATUS) |=> st.flags == $past(st.flags))
      else $error("condition flags changed by operation");
   AST_DEST: assert property (div_done && !st.dest |=> st.opa == $past(div_q))
      else $error("quotient not in dividend register");
   AST_QSET: assert property (st.exec && is_sat && sat_hit |=> st.q && st.rlo == $past(sat_res))
      else $error("saturation did not set flag");
   AST_QHOLD: assert property (st.exec && is_sat && !sat_hit && !wr |=> st.q == $past(st.q))
      else $error("flag changed without clamping");
   AST_QCLR: assert property ($fell(st.q) |-> $past(wr && paddr == ADDR_STATUS))
      else $error("flag cleared without status write");
   AST_USATNEG: assert property (st.exec && st.op == OP_UNSIGNED_WORD_SATURATE && sat_shifted[31]
                                 |=> st.rlo == 32'h0)
      else $error("negative source not clamped to zero");
   AST_SSATMAX: assert property (st.exec && st.op == OP_SIGNED_DUAL_HALF_SATURATE && st.cfg.n == 6'd8
                                 && $signed(st.opa[15:0]) > 16'sd127 |=> st.rlo[15:0] == 16'h007f)
      else $error("low half not clamped");
   AST_SLVERR: assert property (psel && !penable && paddr > ADDR_STATUS |=> pslverr && pready)
      else $error("unmapped address not refused");
endmodule

// file: sim/lmds_issuer_model.sv
// issuer model: apb master standing in for instruction decode
module lmds_issuer_model import lmds_pkg::*; (
   input  wire logic          pclk,    // clock
   output logic      [AW-1:0] paddr,   // byte address
   output logic               psel,    // select
   output logic               penable, // access phase
   output logic               pwrite,  // write direction
   output logic      [DW-1:0] pwdata,  // write data
   input  wire logic [DW-1:0] prdata,  // read data
   input  wire logic          pready,  // transfer done
   input  wire logic          pslverr  // unmapped address
);
   timeunit 1ns;
   timeprecision 1ps;
   ////////////////////////////////////////////////////////////
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
   end
   // one transfer; operands and destinations come from the bench
   task automatic xfer(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d,
                       output logic [DW-1:0] r, output logic e, output logic hung);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      hung = 1'b1;
      while (n < 16) begin
         @(posedge pclk);
         n++;
         if (pready === 1'b1) begin
            hung = 1'b0;
            break;
         end
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // released data is scrambled so no stale value looks valid
      pwdata <= ~d;
   endtask
endmodule

// file: sim/lmds_unit_tb.sv
// self-checking bench of the long multiply, divide and saturate unit
module lmds_unit_tb import lmds_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic          pclk, presetn, psel, penable, pwrite, pready, pslverr, sat_flag, err, hung, exp_q;
   logic [AW-1:0] paddr;
   logic [DW-1:0] pwdata, prdata, rd, seed;
   int            bad_count, checked, cycles;
   ////////////////////////////////////////////////////////////
   lmds_unit lmds_unit_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sat_flag(sat_flag));
   lmds_issuer_model lmds_issuer_model_i (.pclk(pclk), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         bad_count++;
         stop_test();
      end
   end
   ////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [63:0] exp_mul(input logic [3:0] op, input logic [31:0] a, b, hi, lo);
      logic [63:0] p;
      p = (op[1] ? {{32{a[31]}}, a} : {32'h0, a}) * (op[1] ? {{32{b[31]}}, b} : {32'h0, b});
      return op[0] ? p + {hi, lo} : p;
   endfunction
   function automatic logic [31:0] exp_div(input logic sg, input logic [31:0] a, b);
      if (b == 0) return 32'h0;
      if (sg && a == 32'h8000_0000 && b == 32'hffff_ffff) return a;
      // kept apart so the signed divide is not forced unsigned
      if (sg) return $signed(a) / $signed(b);
      return a / b;
   endfunction
   function automatic longint clamp(input longint x, input bit sg, input int n, output logic f);
      longint lo, hi;
      lo = sg ? -(longint'(1) << (n - 1)) : 0;
      hi = sg ? (longint'(1) << (n - 1)) - 1 : (longint'(1) << n) - 1;
      f = (x < lo) || (x > hi);
      return (x < lo) ? lo : ((x > hi) ? hi : x);
   endfunction
   function automatic logic [31:0] exp_sat(input lmds_op_t op, input lmds_satcfg_t c, input logic [31:0] s,
                                           output logic f);
      logic signed [31:0] v;
      longint r1, r2;
      logic f2;
      bit sg;
      sg = (op == OP_SIGNED_WORD_SATURATE) || (op == OP_SIGNED_DUAL_HALF_SATURATE);
      v = s;
      if (op == OP_SIGNED_WORD_SATURATE || op == OP_UNSIGNED_WORD_SATURATE) begin
         if (c.arithmetic_right_shift) v = v >>> c.amt;
         else v = v << c.amt;
         r1 = clamp(longint'(v), sg, int'(c.n), f);
         return r1[31:0];
      end
      r1 = clamp(longint'($signed(s[31:16])), sg, int'(c.n), f);
      r2 = clamp(longint'($signed(s[15:0])), sg, int'(c.n), f2);
      f = f | f2;
      return {r1[15:0], r2[15:0]};
   endfunction
   ////////////////////////////////////////////////////////////
   task automatic chk_word(input logic [DW-1:0] got, exp, input string what);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, exp, input string what);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d);
      lmds_issuer_model_i.xfer(w, a, d, rd, err, hung);
      chk_bit(hung, 1'b0, "pready answer");
   endtask
   task automatic run(input lmds_op_t op, input logic dest);
      int n;
      bus(1'b1, ADDR_CTRL, {27'h0, dest, op});
      n = 0;
      rd = 32'h1;
      while (rd[STAT_BUSY_BIT] !== 1'b0 && n < 60) begin
         bus(1'b0, ADDR_STATUS, '0);
         n++;
      end
      chk_bit(rd[STAT_BUSY_BIT], 1'b0, "busy clears");
   endtask
   ////////////////////////////////////////////////////////////
   task automatic test_regs();
      for (int a = 0; a <= 24; a += 4) begin
         bus(1'b0, AW'(a), '0);
         chk_word(rd, 32'h0, "reset value");
      end
      bus(1'b0, 8'h1c, '0);
      chk_bit(err, 1'b1, "unmapped read error");
      chk_word(rd, 32'h0, "unmapped read data");
      bus(1'b1, 8'h0a, 32'h1234_5678);
      chk_bit(err, 1'b1, "misaligned write error");
      bus(1'b0, ADDR_OPB, '0);
      chk_word(rd, 32'h0, "misaligned write dropped");
      bus(1'b1, ADDR_STATUS, 32'ha0);
      bus(1'b0, ADDR_STATUS, '0);
      chk_word(rd, 32'ha0, "status readback");
      $display("test regs done");
   endtask
   task automatic test_mul();
      logic [31:0] a, b, lo, hi;
      logic [63:0] e;
      for (int i = 0; i < 32; i++) begin
         a = (i < 4) ? 32'hffff_ffff : ((i < 8) ? 32'h8000_0000 : rnd());
         b = (i < 4) ? 32'hffff_ffff : ((i < 8) ? 32'h7fff_ffff : rnd());
         lo = rnd();
         hi = rnd();
         bus(1'b1, ADDR_OPA, a);
         bus(1'b1, ADDR_OPB, b);
         bus(1'b1, ADDR_RLO, lo);
         bus(1'b1, ADDR_RHI, hi);
         run(lmds_op_t'(i % 4), 1'b0);
         e = exp_mul(4'(i % 4), a, b, hi, lo);
         bus(1'b0, ADDR_RLO, '0);
         chk_word(rd, e[31:0], "product low");
         bus(1'b0, ADDR_RHI, '0);
         chk_word(rd, e[63:32], "product high");
      end
      $display("test mul done");
   endtask
   task automatic test_div();
      logic [31:0] a, b;
      for (int i = 0; i < 24; i++) begin
         a = (i == 0) ? 32'h8000_0000 : ((i < 8 && i > 3) ? 32'hffff_fff9 : rnd());
         b = (i == 0) ? 32'hffff_ffff : ((i < 4) ? 32'h0 : ((i < 8) ? 32'h2 : rnd() >> 5'(rnd())));
         bus(1'b1, ADDR_OPA, a);
         bus(1'b1, ADDR_OPB, b);
         bus(1'b1, ADDR_RLO, 32'h5a5a_a5a5);
         run(lmds_op_t'(4 + i % 2), i[1]);
         bus(1'b0, i[1] ? ADDR_RLO : ADDR_OPA, '0);
         chk_word(rd, exp_div(i % 2 == 0, a, b), "quotient");
         bus(1'b0, ADDR_RLO, '0);
         if (!i[1]) chk_word(rd, 32'h5a5a_a5a5, "low kept");
      end
      $display("test div done");
   endtask
   task automatic test_sat();
      lmds_satcfg_t c;
      lmds_op_t op;
      logic [31:0] s, e;
      logic f;
      exp_q = 1'b0;
      for (int i = 0; i < 40; i++) begin
         op = lmds_op_t'(6 + i % 4);
         c.arithmetic_right_shift = rnd() % 2;
         c.amt = c.arithmetic_right_shift ? 5'(1 + rnd() % 31) : 5'(rnd() % 32);
         case (i % 4)
            0: c.n = 6'(1 + rnd() % 32);
            1: c.n = 6'(rnd() % 32);
            2: c.n = 6'(1 + rnd() % 16);
            default: c.n = 6'(rnd() % 16);
         endcase
         // corner: both halves above an 8-bit signed range
         if (i == 2) c.n = 6'd8;
         s = (i / 4 == 3) ? 32'h0 : ((i == 2) ? 32'h0100_0200 : rnd());
         bus(1'b1, ADDR_SATCFG, 32'(c));
         bus(1'b1, ADDR_OPA, s);
         run(op, 1'b0);
         e = exp_sat(op, c, s, f);
         exp_q = exp_q | f;
         bus(1'b0, ADDR_RLO, '0);
         chk_word(rd, e, "saturated value");
         chk_bit(sat_flag, exp_q, "sticky flag");
      end
      bus(1'b0, ADDR_STATUS, '0);
      chk_word(rd, 32'ha0 | {30'h0, exp_q, 1'b0}, "status after ops");
      bus(1'b1, ADDR_STATUS, 32'ha0);
      bus(1'b0, ADDR_STATUS, '0);
      chk_bit(sat_flag, 1'b0, "flag cleared by write");
      chk_word(rd, 32'ha0, "status after clear");
      $display("test sat done");
   endtask
   ////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end
      else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      seed = 32'd94531;
      bad_count = 0;
      checked = 0;
      presetn = 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      test_regs();
      test_mul();
      test_div();
      test_sat();
      stop_test();
   end
endmodule
